// ---- desc_rom_model.sv ----
// description text store seen by the error formatter through desc_addr
// assumes desc_addr = {desc_id, char_index}; answers combinationally, as the formatter expects
`timescale 1ns/1ps
module desc_rom_model (
	input wire logic [15:0] desc_addr,
	output logic [7:0] desc_char_in
);
	// the text of id n spells from letter a+n, so a wrong id shows up in the reply
	assign desc_char_in = 8'h61 + desc_addr[15:8] + {4'h0, desc_addr[3:0]};
endmodule

// ---- error_fifo.sv ----
// error message store: circular fifo with in-place replacement of the newest entry
// assumes the caller never pushes into a full store without a pop in the same cycle
`timescale 1ns/1ps
module error_fifo #(
	parameter int DEPTH = 20,
	parameter int W = 28,
	parameter int CW = 5
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic push,
	input wire logic replace_newest,
	input wire logic [W-1:0] push_data,
	input wire logic pop,
	output logic [W-1:0] head,
	output logic [W-1:0] tail,
	output logic [CW-1:0] count
);
	logic [W-1:0] mem [DEPTH];
	logic [CW-1:0] wr_q, wr_d, rd_q, rd_d, cnt_d, newest;
	logic mem_we;
	logic [CW-1:0] mem_addr;
	if (DEPTH < 2 || DEPTH >= (1 << CW)) begin : g_bad_depth
		$error("error_fifo depth does not fit the counter");
	end
	function automatic logic [CW-1:0] step(input logic [CW-1:0] p);
		step = (p == CW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction
	always_comb begin
		newest = (wr_q == '0) ? CW'(DEPTH - 1) : wr_q - 1'b1;
		wr_d = push ? step(wr_q) : wr_q;
		rd_d = pop ? step(rd_q) : rd_q;
		cnt_d = count + CW'(push) - CW'(pop);
		mem_we = push || replace_newest;
		mem_addr = replace_newest ? newest : wr_q;
		head = mem[rd_q];
		tail = mem[newest];
	end
	always_ff @(posedge clk_sys) begin
		if (mem_we) begin
			mem[mem_addr] <= push_data;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
			count <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			count <= cnt_d;
		end
	end
endmodule

// ---- status_group.sv ----
// one status group: condition edge detection, filters, event latch, enable, summary
// assumes the condition vector is already in the clk_sys domain
`timescale 1ns/1ps
module status_group import status_pkg::*; #(
	parameter int W = WORD_W
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [W-1:0] cond,
	input wire logic [W-1:0] direct_set,
	input wire logic wr_rise,
	input wire logic wr_fall,
	input wire logic wr_enable,
	input wire logic [W-1:0] wr_data,
	input wire logic read_event,
	input wire logic clear_all,
	output logic [W-1:0] rising_edge_filter_q,
	output logic [W-1:0] falling_edge_filter_q,
	output logic [W-1:0] enable_q,
	output logic [W-1:0] event_q,
	output logic group_summary_bit
);
	logic [W-1:0] prev_q, prev_d, rise_d, fall_d, enable_d, event_d, set;
	if (W < 1 || W > WORD_W) begin : g_bad_width
		$error("status_group width out of range");
	end
	always_comb begin
		prev_d = cond;
		rise_d = wr_rise ? wr_data : rising_edge_filter_q; // see (R2)
		fall_d = wr_fall ? wr_data : falling_edge_filter_q; // see (R2)
		enable_d = wr_enable ? wr_data : enable_q; // see (R4)
		set = (cond & ~prev_q & rising_edge_filter_q) | (~cond & prev_q & falling_edge_filter_q) | direct_set; // see (R23)
		// a set arriving with the read or clear survives, so no edge is lost
		event_d = ((read_event || clear_all) ? '0 : event_q) | set; // see (R3)
		group_summary_bit = |(event_q & enable_q); // see (R24)
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prev_q <= '0;
			rising_edge_filter_q <= RISE_RST[W-1:0];
			falling_edge_filter_q <= FALL_RST[W-1:0];
			enable_q <= ENABLE_RST[W-1:0];
			event_q <= EVENT_RST[W-1:0];
		end else begin
			prev_q <= prev_d;
			rising_edge_filter_q <= rise_d;
			falling_edge_filter_q <= fall_d;
			enable_q <= enable_d;
			event_q <= event_d;
		end
	end
endmodule

// ---- status_pkg.sv ----
// constants, types and command codes shared by the status reporting block
// assumes a single clk_sys domain; status_group and status_reporting import the whole package
// Overview of operation
// (R1) condition register is returned on query
// (R2) transition filter masks stored and read back
// (R3) event read returns bits then clears; clear-status too
// (R4) enable register stored and read back
// (R5) error queue is fifo of twenty entries
// (R6) no message waiting summary is produced
// (R7) push entry when event bits 2..5 rise
// (R8) entry printed as number, comma, quoted text
// (R9) description text never longer than 255 characters
// (R10) full queue: newest entry becomes overflow -350
// (R11) empty queue answers +0 and no error
// (R12) each error read removes the returned entry
// (R13) controller reads number then string reply
// (R14) hardware-1 summary drives status byte bit zero
// (R15) hardware-1 bit 6 is communication group summary
// (R16) bits 12..9 report decoder status flags
// (R17) bit 8: two fields both being sent
// (R18) bit 7: one field being sent
// (R19) bit 7 inactive in function generator mode
// (R20) bit 5 set on measurement limit crossing
// (R21) bit 4 self test failed, bit 3 overpower
// (R22) bits 15,2 zero; 1 mike, 0 battery
// (R23) event latches on filtered rising or falling edge
// (R24) summary is or of enabled event bits
package status_pkg;
	localparam int WORD_W = 16;
	localparam int QUEUE_DEPTH = 20;
	localparam int CNT_W = 5;
	localparam int DESC_MAX = 255;
	localparam int CODE_W = 11;
	localparam logic [10:0] CODE_OVERFLOW = 11'h6a2;
	localparam logic [10:0] CODE_NO_ERROR = 11'h000;
	localparam logic [15:0] RISE_RST = 16'hffff;
	localparam logic [15:0] FALL_RST = 16'h0000;
	localparam logic [15:0] ENABLE_RST = 16'h0000;
	localparam logic [15:0] EVENT_RST = 16'h0000;
	localparam logic [15:0] COMM_LIVE_MASK = 16'h7fff;
	localparam int HW1_BIT_COMM = 6;
	localparam int HW1_BIT_LIMIT = 5;
	localparam int HW1_BIT_INFO = 7;
	localparam int HW1_BIT_AUX = 8;
	localparam int SEV_LO = 2;
	localparam int SEV_HI = 5;
	localparam logic [7:0] MSG_NO_ERROR = 8'h00;
	localparam logic [7:0] MSG_OVERFLOW = 8'h01;
	localparam logic [7:0] LEN_NO_ERROR = 8'h08;
	localparam logic [7:0] LEN_OVERFLOW = 8'h0e;
	localparam logic [63:0] TXT_NO_ERROR = "No error";
	localparam logic [111:0] TXT_OVERFLOW = "Queue overflow";
	localparam logic [7:0] CH_PLUS = 8'h2b;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_QUOTE = 8'h22;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic GRP_COMM = 1'b0;
	localparam logic GRP_HW1 = 1'b1;
	typedef enum logic [3:0] {
		CMD_COND_Q = 4'h0, CMD_RISE_Q = 4'h1, CMD_FALL_Q = 4'h2, CMD_RISE_W = 4'h3,
		CMD_FALL_W = 4'h4, CMD_EVENT_Q = 4'h5, CMD_ENABLE_Q = 4'h6, CMD_ENABLE_W = 4'h7,
		CMD_CLS = 4'h8, CMD_ERR_Q = 4'h9
	} cmd_t;
	typedef enum logic [7:0] {
		F_IDLE = 8'h01, F_SIGN = 8'h02, F_DIG = 8'h04, F_COMMA = 8'h08,
		F_OQ = 8'h10, F_FETCH = 8'h20, F_CHAR = 8'h40, F_CQ = 8'h80
	} fmt_state_t;
	typedef struct packed {
		logic builtin;
		logic [10:0] code;
		logic [7:0] id;
		logic [7:0] len;
	} entry_t;
endpackage

// ---- status_reporting.sv ----
// status reporting top: communication and hardware-1 groups, error queue and its text formatter
// assumes commands and decoder/encoder flags come from clk_sys logic; panel-side flags are async pins
`timescale 1ns/1ps
module status_reporting import status_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire cmd_t cmd_code,
	input wire logic cmd_group,
	input wire logic [15:0] cmd_data,
	output logic cmd_ready,
	output logic reg_resp_valid,
	output logic [15:0] reg_resp_data,
	output logic err_char_valid,
	output logic [7:0] err_char,
	output logic err_char_last,
	output logic [15:0] desc_addr,
	input wire logic [7:0] desc_char_in,
	input wire logic [7:0] std_event_bits,
	input wire logic [10:0] err_code,
	input wire logic [7:0] err_desc_id,
	input wire logic [7:0] err_desc_len,
	input wire logic [15:0] comm_cond,
	input wire logic [1:0] rib_irq,
	input wire logic dec_results,
	input wire logic dec_level_low,
	input wire logic dec_measuring,
	input wire logic dec_armed,
	input wire logic enc_two_field_mode,
	input wire logic [1:0] enc_field_sent,
	input wire logic enc_func_gen,
	input wire logic meas_limit_hit,
	input wire logic selftest_fail,
	input wire logic overpower_trip,
	input wire logic ext_mike_keyed,
	input wire logic battery_low,
	output logic comm_summary,
	output logic hw1_summary,
	output logic status_byte_bit0,
	output logic [4:0] queue_count
);
	// pin flags: {rib_irq[1:0], limit, selftest, overpower, mike, battery}
	logic [6:0] pin_s1_q, pin_s2_q, limit_prev_q;
	logic [3:0] sev_prev_q;
	logic [15:0] hw1_cond, hw1_direct, comm_live;
	logic [15:0] comm_rise, comm_fall, comm_enable, comm_event;
	logic [15:0] hw1_rise, hw1_fall, hw1_enable, hw1_event;
	logic comm_sum, hw1_sum;
	logic [3:0] sev_rise;
	logic err_event, q_full, q_empty, q_push, q_replace, q_pop;
	entry_t q_head, q_tail, q_new;
	logic [4:0] q_count;
	logic acc, cmd_comm, cmd_hw1;
	logic wr_rise_c, wr_fall_c, wr_en_c, rd_ev_c, wr_rise_h, wr_fall_h, wr_en_h, rd_ev_h, cls;
	fmt_state_t st_q, st_d;
	entry_t cur_q, cur_d;
	logic [9:0] mag, q100, q10;
	logic [3:0] digits [3];
	logic [1:0] ndig, dig_q, dig_d;
	logic [7:0] idx_q, idx_d, builtin_ch;
	logic [15:0] addr_q, addr_d, resp_data_d;
	logic resp_valid_d, out_valid_d, out_last_d, ready_d;
	logic [7:0] out_char_d;

	// the pin flags come from the front panel and supply monitors, not from clk_sys logic
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			limit_prev_q <= '0;
			sev_prev_q <= '0;
		end else begin
			pin_s1_q <= {rib_irq, meas_limit_hit, selftest_fail, overpower_trip, ext_mike_keyed, battery_low};
			pin_s2_q <= pin_s1_q;
			limit_prev_q <= pin_s2_q;
			sev_prev_q <= std_event_bits[SEV_HI:SEV_LO];
		end
	end

	always_comb begin
		comm_live = comm_cond & COMM_LIVE_MASK;
		hw1_cond = '0; // see (R22)
		hw1_cond[14:13] = pin_s2_q[6:5];
		hw1_cond[12:9] = {dec_results, dec_level_low, dec_measuring, dec_armed}; // see (R16)
		hw1_cond[HW1_BIT_AUX] = enc_two_field_mode && (&enc_field_sent); // see (R17)
		// function generator mode forces bit 7 low; bit 8 still follows the field flags
		hw1_cond[HW1_BIT_INFO] = !enc_func_gen && (enc_two_field_mode ? ^enc_field_sent : enc_field_sent[0]); // see (R18) (R19)
		hw1_cond[HW1_BIT_COMM] = comm_sum; // see (R15)
		hw1_cond[4:3] = pin_s2_q[3:2]; // see (R21)
		hw1_cond[1:0] = pin_s2_q[1:0]; // see (R22)
		// the limit flag has no condition bit, so its crossing lands straight in the event register
		hw1_direct = '0;
		hw1_direct[HW1_BIT_LIMIT] = pin_s2_q[4] && !limit_prev_q[4]; // see (R20)
	end

	status_group #(.W(WORD_W)) u_comm (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.cond(comm_live),
		.direct_set(16'h0000),
		.wr_rise(wr_rise_c),
		.wr_fall(wr_fall_c),
		.wr_enable(wr_en_c),
		.wr_data(cmd_data),
		.read_event(rd_ev_c),
		.clear_all(cls),
		.rising_edge_filter_q(comm_rise),
		.falling_edge_filter_q(comm_fall),
		.enable_q(comm_enable),
		.event_q(comm_event),
		.group_summary_bit(comm_sum)
	);

	status_group #(.W(WORD_W)) u_hw1 (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.cond(hw1_cond),
		.direct_set(hw1_direct),
		.wr_rise(wr_rise_h),
		.wr_fall(wr_fall_h),
		.wr_enable(wr_en_h),
		.wr_data(cmd_data),
		.read_event(rd_ev_h),
		.clear_all(cls),
		.rising_edge_filter_q(hw1_rise),
		.falling_edge_filter_q(hw1_fall),
		.enable_q(hw1_enable),
		.event_q(hw1_event),
		.group_summary_bit(hw1_sum)
	);

	// several status bits rising together stand for one error report
	always_comb begin
		sev_rise = std_event_bits[SEV_HI:SEV_LO] & ~sev_prev_q;
		err_event = |sev_rise; // see (R7)
		q_full = (q_count == 5'(QUEUE_DEPTH));
		q_empty = (q_count == 5'h00);
		q_push = err_event && (!q_full || q_pop); // see (R5)
		q_replace = err_event && q_full && !q_pop; // see (R10)
		q_new.builtin = q_replace;
		q_new.code = q_replace ? CODE_OVERFLOW : err_code;
		q_new.id = q_replace ? MSG_OVERFLOW : err_desc_id;
		q_new.len = q_replace ? LEN_OVERFLOW : err_desc_len; // see (R9)
	end

	error_fifo #(.DEPTH(QUEUE_DEPTH), .W($bits(entry_t)), .CW(CNT_W)) u_queue (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.push(q_push),
		.replace_newest(q_replace),
		.push_data(q_new),
		.pop(q_pop),
		.head(q_head),
		.tail(q_tail),
		.count(q_count) // only the count is taken out to the top as queue_count, no message-waiting summary, see (R6)
	);

	// decimal digits of the stored code, most significant first when printed
	always_comb begin
		mag = cur_q.code[10] ? 10'(-cur_q.code) : cur_q.code[9:0];
		q100 = mag / 10'd100;
		q10 = mag / 10'd10;
		digits[2] = q100[3:0];
		digits[1] = 4'(q10 % 10'd10);
		digits[0] = 4'(mag % 10'd10);
		ndig = (mag >= 10'd100) ? 2'd3 : (mag >= 10'd10) ? 2'd2 : 2'd1;
		builtin_ch = (cur_q.id == MSG_OVERFLOW) ? TXT_OVERFLOW[8 * (LEN_OVERFLOW - 8'h01 - idx_q) +: 8]
			: TXT_NO_ERROR[8 * (LEN_NO_ERROR - 8'h01 - idx_q) +: 8];
	end

	// command decode and reply formatter; replies are never overlapped, so ready drops while printing
	always_comb begin
		acc = cmd_valid && (st_q == F_IDLE);
		cmd_comm = acc && (cmd_group == GRP_COMM);
		cmd_hw1 = acc && (cmd_group == GRP_HW1);
		wr_rise_c = cmd_comm && (cmd_code == CMD_RISE_W);
		wr_fall_c = cmd_comm && (cmd_code == CMD_FALL_W);
		wr_en_c = cmd_comm && (cmd_code == CMD_ENABLE_W);
		rd_ev_c = cmd_comm && (cmd_code == CMD_EVENT_Q);
		wr_rise_h = cmd_hw1 && (cmd_code == CMD_RISE_W);
		wr_fall_h = cmd_hw1 && (cmd_code == CMD_FALL_W);
		wr_en_h = cmd_hw1 && (cmd_code == CMD_ENABLE_W);
		rd_ev_h = cmd_hw1 && (cmd_code == CMD_EVENT_Q); // see (R3)
		cls = acc && (cmd_code == CMD_CLS); // see (R3)
		q_pop = acc && (cmd_code == CMD_ERR_Q) && !q_empty; // see (R12)
		st_d = st_q;
		cur_d = cur_q;
		dig_d = dig_q;
		idx_d = idx_q;
		addr_d = addr_q;
		resp_valid_d = 1'b0;
		resp_data_d = reg_resp_data;
		out_valid_d = 1'b0;
		out_last_d = 1'b0;
		out_char_d = err_char;
		case (st_q)
			F_IDLE: begin
				if (acc) begin
					resp_valid_d = (cmd_code != CMD_CLS) && (cmd_code != CMD_ERR_Q);
					case (cmd_code)
						CMD_COND_Q: resp_data_d = cmd_group ? hw1_cond : comm_live; // see (R1)
						CMD_RISE_Q: resp_data_d = cmd_group ? hw1_rise : comm_rise; // see (R2)
						CMD_FALL_Q: resp_data_d = cmd_group ? hw1_fall : comm_fall; // see (R2)
						CMD_EVENT_Q: resp_data_d = cmd_group ? hw1_event : comm_event; // see (R3)
						CMD_ENABLE_Q: resp_data_d = cmd_group ? hw1_enable : comm_enable; // see (R4)
						CMD_ERR_Q: begin
							if (q_empty) begin
								cur_d = '{builtin: 1'b1, code: CODE_NO_ERROR, id: MSG_NO_ERROR, len: LEN_NO_ERROR}; // see (R11)
							end else begin
								cur_d = q_head;
							end
							st_d = F_SIGN;
						end
						default: resp_data_d = cmd_data;
					endcase
				end
			end
			F_SIGN: begin
				out_valid_d = 1'b1;
				out_char_d = cur_q.code[10] ? CH_MINUS : CH_PLUS; // see (R8)
				dig_d = ndig - 2'd1;
				st_d = F_DIG;
			end
			F_DIG: begin
				out_valid_d = 1'b1;
				out_char_d = CH_ZERO + {4'h0, digits[dig_q]};
				dig_d = dig_q - 2'd1;
				st_d = (dig_q == 2'd0) ? F_COMMA : F_DIG;
			end
			F_COMMA: begin
				out_valid_d = 1'b1;
				out_char_d = CH_COMMA; // see (R8)
				st_d = F_OQ;
			end
			F_OQ: begin
				out_valid_d = 1'b1;
				out_char_d = CH_QUOTE;
				idx_d = 8'h00;
				st_d = (cur_q.len == 8'h00) ? F_CQ : F_FETCH;
			end
			F_FETCH: begin
				addr_d = {cur_q.id, idx_q};
				st_d = F_CHAR;
			end
			F_CHAR: begin
				out_valid_d = 1'b1;
				out_char_d = cur_q.builtin ? builtin_ch : desc_char_in;
				idx_d = idx_q + 8'h01;
				// an 8-bit length caps the text at the allowed maximum
				st_d = (idx_q == cur_q.len - 8'h01) ? F_CQ : F_FETCH; // see (R9)
			end
			F_CQ: begin
				out_valid_d = 1'b1;
				out_char_d = CH_QUOTE;
				out_last_d = 1'b1; // see (R13)
				st_d = F_IDLE;
			end
			default: st_d = F_IDLE;
		endcase
		ready_d = (st_d == F_IDLE);
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= F_IDLE;
			cur_q <= '0;
			dig_q <= 2'd0;
			idx_q <= 8'h00;
			addr_q <= 16'h0000;
			cmd_ready <= 1'b1;
			reg_resp_valid <= 1'b0;
			reg_resp_data <= 16'h0000;
			err_char_valid <= 1'b0;
			err_char <= 8'h00;
			err_char_last <= 1'b0;
			comm_summary <= 1'b0;
			hw1_summary <= 1'b0;
			status_byte_bit0 <= 1'b0;
		end else begin
			st_q <= st_d;
			cur_q <= cur_d;
			dig_q <= dig_d;
			idx_q <= idx_d;
			addr_q <= addr_d;
			cmd_ready <= ready_d;
			reg_resp_valid <= resp_valid_d;
			reg_resp_data <= resp_data_d;
			err_char_valid <= out_valid_d;
			err_char <= out_char_d;
			err_char_last <= out_last_d;
			comm_summary <= comm_sum;
			hw1_summary <= hw1_sum;
			status_byte_bit0 <= hw1_sum; // see (R14)
		end
	end

	always_comb begin
		desc_addr = addr_q;
		queue_count = q_count;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_empty_err_query;
		acc && cmd_code == CMD_ERR_Q && q_empty;
	endsequence
	sequence s_no_error_head;
		##2 err_char_valid && err_char == CH_PLUS ##1 err_char == CH_ZERO ##1 err_char == CH_COMMA;
	endsequence

	a_cond_reply: assert property ( // see (R1)
		cmd_hw1 && cmd_code == CMD_COND_Q |=> reg_resp_valid && reg_resp_data == $past(hw1_cond))
		else $error("condition query reply wrong");
	a_filter_store: assert property ( // see (R2)
		wr_fall_c ##1 !wr_fall_c |-> comm_fall == $past(cmd_data))
		else $error("falling filter not stored");
	a_event_read: assert property ( // see (R3)
		rd_ev_c |=> reg_resp_data == $past(comm_event) && (comm_event & ~($past(comm_live) ^ $past(comm_live, 2))) == 16'h0000)
		else $error("event read reply wrong");
	a_enable_keep: assert property ( // see (R4)
		wr_en_h ##1 !wr_en_h [*3] |-> hw1_enable == $past(cmd_data, 3))
		else $error("enable value not kept");
	a_queue_bound: assert property ( // see (R5)
		q_count <= 5'(QUEUE_DEPTH))
		else $error("error queue above depth");
	a_push_on_bit: assert property ( // see (R7)
		err_event && !q_full && !q_pop |=> q_count == $past(q_count) + 5'h01)
		else $error("error event not queued");
	a_overflow_mark: assert property ( // see (R10)
		q_replace |=> q_tail.code == CODE_OVERFLOW && q_count == 5'(QUEUE_DEPTH))
		else $error("overflow entry missing");
	a_empty_reply: assert property ( // see (R11)
		s_empty_err_query |-> s_no_error_head)
		else $error("empty queue reply wrong");
	a_pop_on_read: assert property ( // see (R12)
		q_pop && !err_event |=> q_count == $past(q_count) - 5'h01)
		else $error("read did not remove entry");
	a_reply_ends: assert property ( // see (R8)
		acc && cmd_code == CMD_ERR_Q |-> ##[6:600] err_char_last && err_char == CH_QUOTE)
		else $error("error reply never closed");
	a_sb_bit0: assert property ( // see (R14)
		status_byte_bit0 == $past(|(hw1_event & hw1_enable)))
		else $error("status byte bit zero mismatch");
	a_comm_into_hw1: assert property ( // see (R15)
		hw1_cond[HW1_BIT_COMM] == |(comm_event & comm_enable))
		else $error("hardware-1 bit 6 not communication summary");
	a_bit7_fgen: assert property ( // see (R19)
		enc_func_gen |-> !hw1_cond[HW1_BIT_INFO] && !(hw1_cond[HW1_BIT_INFO] && hw1_cond[HW1_BIT_AUX]))
		else $error("bit 7 active in function generator mode");
	a_unused_zero: assert property ( // see (R22)
		!hw1_cond[15] && !hw1_cond[2] && !hw1_cond[HW1_BIT_LIMIT])
		else $error("unused hardware-1 bit set");
endmodule

// ---- tb_status_reporting.sv ----
// self-checking bench for status_reporting: register groups, hardware-1 map, error queue
// assumes desc_rom_model answers the description fetches
`timescale 1ns/1ps
module tb_status_reporting import status_pkg::*;;
	logic clk_sys, rst_b, cmd_valid, cmd_group, cmd_ready, reg_resp_valid;
	cmd_t cmd_code;
	logic [15:0] cmd_data, reg_resp_data, desc_addr, comm_cond;
	logic err_char_valid, err_char_last, comm_summary, hw1_summary, status_byte_bit0;
	logic [7:0] err_char, desc_char_in, std_event_bits, err_desc_id, err_desc_len;
	logic [10:0] err_code;
	logic [1:0] rib_irq, enc_field_sent;
	logic dec_results, dec_level_low, dec_measuring, dec_armed, enc_two_field_mode, enc_func_gen;
	logic meas_limit_hit, selftest_fail, overpower_trip, ext_mike_keyed, battery_low;
	logic [4:0] queue_count;
	int num_errors = 0;
	int compares = 0;

	status_reporting i_dut (.*);
	desc_rom_model i_rom (.desc_addr(desc_addr), .desc_char_in(desc_char_in));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic conclude();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [319:0] seen, input logic [319:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask

	// a command stands until an edge that sees cmd_ready high; that edge takes it
	task automatic cmd(input cmd_t c, input logic g, input logic [15:0] d);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_group <= g;
		cmd_data <= d;
		do begin
			@(negedge clk_sys);
		end while (cmd_ready !== 1'b1);
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
	endtask

	task automatic query(input cmd_t c, input logic g, input logic [15:0] exp);
		cmd(c, g, 16'h0000);
		@(negedge clk_sys);
		check({reg_resp_valid, reg_resp_data}, {1'b1, exp});
	endtask

	task automatic read_err(input logic [319:0] exp);
		logic [319:0] got;
		int n;
		got = '0;
		n = 0;
		cmd(CMD_ERR_Q, 1'b0, 16'h0000);
		@(negedge clk_sys);
		check(cmd_ready, 1'b0);
		do begin
			@(negedge clk_sys);
			if (err_char_valid === 1'b1)
				got = {got[311:0], err_char};
			n++;
		end while (err_char_last !== 1'b1 && n < 800);
		check(got, exp);
		@(negedge clk_sys);
		check(cmd_ready, 1'b1);
	endtask

	// the description id follows the status bit, so each entry reads back its own text
	task automatic push_err(input logic [10:0] code, input logic [7:0] len, input int b);
		@(posedge clk_sys);
		std_event_bits <= 8'h01 << b;
		err_code <= code;
		err_desc_id <= 8'(b);
		err_desc_len <= len;
		@(posedge clk_sys);
		std_event_bits <= 8'h00;
		@(negedge clk_sys);
	endtask

	function automatic logic [15:0] hw1_exp(input logic comm_sum);
		return {1'b0, rib_irq, dec_results, dec_level_low, dec_measuring, dec_armed,
			enc_two_field_mode & (&enc_field_sent),
			~enc_func_gen & (enc_two_field_mode ? ^enc_field_sent : enc_field_sent[0]),
			comm_sum, 1'b0, selftest_fail, overpower_trip, 1'b0, ext_mike_keyed, battery_low};
	endfunction

	task automatic t_reset_values();
		for (int g = 0; g < 2; g++) begin
			query(CMD_RISE_Q, g[0], RISE_RST);
			query(CMD_FALL_Q, g[0], FALL_RST);
			query(CMD_ENABLE_Q, g[0], ENABLE_RST);
			query(CMD_EVENT_Q, g[0], EVENT_RST);
		end
	endtask

	// every signalling combination, with the decoder and panel flags moving too
	task automatic t_hw1_map();
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			{enc_two_field_mode, enc_field_sent, enc_func_gen} <= i[3:0];
			{dec_results, dec_level_low, dec_measuring, dec_armed} <= ~i[3:0];
			{rib_irq, selftest_fail, overpower_trip, ext_mike_keyed, battery_low} <= 6'(i * 7);
			repeat (4) @(posedge clk_sys);
			query(CMD_COND_Q, 1'b1, hw1_exp(1'b0));
		end
	endtask

	task automatic t_masks();
		for (int g = 0; g < 2; g++) begin
			cmd(CMD_RISE_W, g[0], 16'h0100);
			cmd(CMD_FALL_W, g[0], 16'h0201);
			cmd(CMD_ENABLE_W, g[0], 16'd256);
			query(CMD_RISE_Q, g[0], 16'h0100);
			query(CMD_FALL_Q, g[0], 16'h0201);
			query(CMD_ENABLE_Q, g[0], 16'd256);
		end
	endtask

	task automatic t_comm_events();
		cmd(CMD_EVENT_Q, 1'b0, 16'h0000);
		cmd(CMD_RISE_W, 1'b0, 16'h0001);
		cmd(CMD_FALL_W, 1'b0, 16'h0002);
		cmd(CMD_ENABLE_W, 1'b0, 16'h0001);
		@(posedge clk_sys);
		comm_cond <= 16'h0003;
		repeat (3) @(posedge clk_sys);
		comm_cond <= 16'h0001;
		repeat (3) @(negedge clk_sys);
		check(comm_summary, 1'b1);
		query(CMD_COND_Q, 1'b1, hw1_exp(1'b1));
		query(CMD_COND_Q, 1'b0, 16'h0001);
		query(CMD_EVENT_Q, 1'b0, 16'h0003);
		query(CMD_EVENT_Q, 1'b0, 16'h0000);
		check(comm_summary, 1'b0);
		@(posedge clk_sys);
		comm_cond <= 16'h0000;
		repeat (3) @(posedge clk_sys);
		comm_cond <= 16'h0001;
		repeat (3) @(posedge clk_sys);
		cmd(CMD_CLS, 1'b0, 16'h0000);
		query(CMD_EVENT_Q, 1'b0, 16'h0000);
	endtask

	task automatic t_limit_summary();
		cmd(CMD_ENABLE_W, 1'b1, 16'h0020);
		@(posedge clk_sys);
		meas_limit_hit <= 1'b1;
		repeat (6) @(negedge clk_sys);
		check({hw1_summary, status_byte_bit0}, 2'b11);
		query(CMD_COND_Q, 1'b1, hw1_exp(1'b0));
		cmd(CMD_CLS, 1'b0, 16'h0000);
		meas_limit_hit <= 1'b0;
		repeat (3) @(negedge clk_sys);
		check({hw1_summary, status_byte_bit0}, 2'b00);
	endtask

	task automatic t_queue();
		read_err("+0,\"No error\"");
		push_err(11'h78f, 8'd3, 2);
		check(queue_count, 5'd1);
		read_err("-113,\"cde\"");
		push_err(11'h001, 8'd1, 0);
		push_err(11'h001, 8'd1, 1);
		check(queue_count, 5'd0);
		for (int k = 1; k <= 20; k++)
			push_err(11'(k), 8'd1, 2 + k % 4);
		check(queue_count, 5'd20);
		push_err(11'h005, 8'd1, 3);
		check(queue_count, 5'd20);
		for (int k = 1; k < 20; k++)
			read_err({k < 10 ? {"+", 8'(8'h30 + k)} : {"+1", 8'(8'h26 + k)}, ",\"", 8'(8'h63 + k % 4), "\""});
		read_err("-350,\"Queue overflow\"");
		check(queue_count, 5'd0);
		read_err("+0,\"No error\"");
	endtask

	initial begin
		{rst_b, cmd_valid, cmd_group, cmd_data, comm_cond, std_event_bits} = '0;
		{err_code, err_desc_id, err_desc_len, rib_irq, enc_field_sent} = '0;
		{dec_results, dec_level_low, dec_measuring, dec_armed, enc_two_field_mode} = '0;
		{enc_func_gen, meas_limit_hit, selftest_fail, overpower_trip, ext_mike_keyed, battery_low} = '0;
		cmd_code = CMD_COND_Q;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset_values();
		t_hw1_map();
		t_masks();
		t_comm_events();
		t_limit_summary();
		t_queue();
		conclude();
	end

	// the whole sequence needs a few hundred cycles
	initial begin
		#300us;
		num_errors++;
		conclude();
	end
endmodule
